// File: hw/isrp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// plain synchronous FIFO, full and empty are exact
module isrp_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW:0]      wrPtr;       // extra bit tells full from empty
	logic [AW:0]      rdPtr;
	wire              push = inValid & inReady;
	wire              pop  = outValid & outReady;
	assign inReady  = (wrPtr[AW-1:0] != rdPtr[AW-1:0]) | (wrPtr[AW] == rdPtr[AW]);
	assign outValid = (wrPtr != rdPtr);
	assign outData  = mem[rdPtr[AW-1:0]];
	// pointer and storage update
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (push) begin
				mem[wrPtr[AW-1:0]] <= inData;
				wrPtr              <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule : isrp_fifo

// host end: SPI mode 3 master, one frame per request, answers through the FIFO
module isrp_host_port
	import isrp_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	isrp_link_if.host       link,
	input  wire logic       reqValid,   // request word offered
	output logic            reqReady,   // request taken this cycle
	input  wire isrp_word_t reqWord,    // word shifted out MSB first
	input  wire logic       reqKeepSel, // keep select low after this frame
	output logic            rdValid,    // received word available
	input  wire logic       rdReady,    // user takes received word
	output isrp_word_t      rdWord,
	output logic            sampleSeen, // synchronised sample-done strobe
	input  wire logic       syncDrive,  // user drive value for sync pin
	input  wire logic       syncDriveOe
);
	typedef enum logic [2:0] {
		ISRP_H_IDLE  = 3'b000,
		ISRP_H_SETUP = 3'b001,
		ISRP_H_LOW   = 3'b010,
		ISRP_H_HIGH  = 3'b011,
		ISRP_H_GAP   = 3'b100
	} isrp_hstate_t;
	isrp_hstate_t state;
	logic [8:0]   cnt;       // phase timer
	logic [3:0]   bitCnt;    // bit of the frame
	isrp_word_t   txShift;   // outgoing request
	isrp_word_t   rxShift;   // incoming answer
	logic         keep;      // hold select after frame
	logic         pushValid; // one-cycle push of a finished frame
	logic         fifoReady;
	logic [1:0]   misoSync;  // first stage read only by second
	logic [1:0]   doneSync;  // sample-done strobe synchroniser
	wire          phaseEnd = (cnt == 9'(SCLK_HALF_CYC - 1));
	assign reqReady = (state == ISRP_H_IDLE) & fifoReady & ~pushValid;

	// pin synchronisers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			misoSync <= 2'h0;
			doneSync <= 2'h0;
		end else begin
			misoSync <= {misoSync[0], link.miso};
			doneSync <= {doneSync[0], link.sampleDone};
		end
	end

	// frame sequencer; clock idles high and falls first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state     <= ISRP_H_IDLE;
			cnt       <= '0;
			bitCnt    <= '0;
			txShift   <= '0;
			rxShift   <= '0;
			keep      <= 1'b0;
			pushValid <= 1'b0;
			link.selN <= 1'b1;
			link.sclk <= 1'b1;
			link.mosi <= 1'b0;
		end else begin
			pushValid <= 1'b0;
			cnt       <= cnt + 9'h1;
			unique case (state)
				ISRP_H_IDLE: begin
					cnt <= '0;
					if (reqReady && reqValid) begin
						txShift   <= reqWord;
						keep      <= reqKeepSel;
						bitCnt    <= '0;
						link.selN <= 1'b0;
						if (!link.selN) begin
							link.sclk <= 1'b0;
							link.mosi <= reqWord[15];
							state     <= ISRP_H_LOW;
						end else begin
							state <= ISRP_H_SETUP;
						end
					end
				end
				ISRP_H_SETUP: begin
					if (cnt == 9'(CS_SETUP_CYC - 1)) begin
						cnt       <= '0;
						link.sclk <= 1'b0;
						link.mosi <= txShift[15];
						state     <= ISRP_H_LOW;
					end
				end
				ISRP_H_LOW: begin
					if (phaseEnd) begin
						cnt       <= '0;
						link.sclk <= 1'b1;
						rxShift   <= {rxShift[14:0], misoSync[1]};
						state     <= ISRP_H_HIGH;
					end
				end
				ISRP_H_HIGH: begin
					if (phaseEnd) begin
						cnt <= '0;
						if (bitCnt == 4'hf) begin
							pushValid <= 1'b1;
							state     <= keep ? ISRP_H_IDLE : ISRP_H_GAP;
							link.selN <= ~keep;
						end else begin
							bitCnt    <= bitCnt + 4'h1;
							txShift   <= {txShift[14:0], 1'b0};
							link.mosi <= txShift[14];
							link.sclk <= 1'b0;
							state     <= ISRP_H_LOW;
						end
					end
				end
				ISRP_H_GAP: begin
					if (cnt == 9'(STALL_CYC - 1)) begin
						state <= ISRP_H_IDLE;
					end
				end
				default: state <= ISRP_H_IDLE;
			endcase
		end
	end

	// answers wait here; a full FIFO holds off the next request
	isrp_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_isrp_fifo (
		.core_clk(core_clk),
		.rst     (rst),
		.inValid (pushValid),
		.inReady (fifoReady),
		.inData  (rxShift),
		.outValid(rdValid),
		.outReady(rdReady),
		.outData (rdWord)
	);

	assign sampleSeen       = doneSync[1];
	assign link.syncHostOut = syncDrive;
	assign link.syncHostOe  = syncDriveOe;
endmodule : isrp_host_port
`default_nettype wire

// File: hw/isrp_sensor_port.sv
// Notes on behaviour
// - samples autonomously after reset, no commands
// - output registers refresh at 2048 per second
// - sample-done strobe pulses high each sample
// - output bit changes on serial clock fall
// - input bit captured on serial clock rise
// - host runs mode 3, clock idles high
// - sixteen-bit frames, MSB first, full duplex
// - device is slave only, makes no clock
// - one read costs two frames
// - low byte of read request ignored
// - requested word returns in next frame
// - next request rides on answer frame
// - rate upper words at 0x06, 0x0A, 0x0E
// - host serial clock at most 1 MHz burst
// - sync pin direction from control register field
// - host stalls 16 us between normal frames
// - write frame carries flag, address, data byte
// - request 0x3E00 starts streamed burst words
`timescale 1ns/1ps
`default_nettype none
module isrp_sensor_port
	import isrp_pkg::*;
#(
	parameter int unsigned SAMPLE_CYC = SAMPLE_PERIOD_CYC // cycles per sample, shorten in simulation
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	isrp_link_if.dev        link,
	input  wire isrp_word_t rateX,     // sensor front end words, same clock
	input  wire isrp_word_t rateY,
	input  wire isrp_word_t rateZ,
	input  wire isrp_word_t accelX,
	input  wire isrp_word_t accelY,
	input  wire isrp_word_t accelZ,
	input  wire isrp_word_t tempIn,
	input  wire isrp_word_t diagIn,
	output logic            sampleTick, // one cycle per sample taken
	output isrp_word_t      miscCtrl    // miscellaneous_control_reg contents
);
	// fresh value for each output register slot, indexed by byte address / 2
	function automatic isrp_word_t isrp_fresh(input logic [3:0] idx, input isrp_word_t rx, input isrp_word_t ry,
		input isrp_word_t rz, input isrp_word_t ax, input isrp_word_t ay, input isrp_word_t az,
		input isrp_word_t tp, input isrp_word_t dg, input isrp_word_t cnt);
		isrp_fresh = '0;
		unique case (idx)
			ADDR_DIAG[4:1]:   isrp_fresh = dg;
			ADDR_RATE_X[4:1]: isrp_fresh = rx;
			ADDR_RATE_Y[4:1]: isrp_fresh = ry;
			ADDR_RATE_Z[4:1]: isrp_fresh = rz;
			ADDR_ACCL_X[4:1]: isrp_fresh = ax;
			ADDR_ACCL_Y[4:1]: isrp_fresh = ay;
			ADDR_ACCL_Z[4:1]: isrp_fresh = az;
			ADDR_SMPL[4:1]:   isrp_fresh = cnt;
			ADDR_TEMP[4:1]:   isrp_fresh = tp;
			default:          isrp_fresh = '0; // low words and unused slots
		endcase
	endfunction : isrp_fresh

	// order of words streamed in a burst; the last slot is the checksum
	function automatic logic [6:0] isrp_burst_addr(input logic [3:0] idx);
		isrp_burst_addr = ADDR_DIAG;
		unique case (idx)
			4'h0:    isrp_burst_addr = ADDR_DIAG;
			4'h1:    isrp_burst_addr = ADDR_RATE_X;
			4'h2:    isrp_burst_addr = ADDR_RATE_Y;
			4'h3:    isrp_burst_addr = ADDR_RATE_Z;
			4'h4:    isrp_burst_addr = ADDR_ACCL_X;
			4'h5:    isrp_burst_addr = ADDR_ACCL_Y;
			4'h6:    isrp_burst_addr = ADDR_ACCL_Z;
			4'h7:    isrp_burst_addr = ADDR_TEMP;
			default: isrp_burst_addr = ADDR_SMPL; // slot 8, slot 9 is overridden
		endcase
	endfunction : isrp_burst_addr

	// byte pair sum used by the checksum
	function automatic logic [15:0] isrp_bytes(input isrp_word_t w);
		isrp_bytes = {8'h00, w[15:8]} + {8'h00, w[7:0]};
	endfunction : isrp_bytes

	// pin synchronisers: bit 0 is the first stage, bit 2 only feeds edge detect
	logic [2:0]  sclkSync;
	logic [1:0]  selSync;
	logic [1:0]  mosiSync;
	logic [2:0]  syncPinSync;
	// serial engine
	logic [3:0]  bitCnt;      // bits taken in this frame
	isrp_word_t  rxShift;     // incoming request bits
	isrp_word_t  txShift;     // answer waiting to shift out
	logic        misoBit;     // registered output bit
	logic        burstActive; // streaming a burst
	logic [3:0]  burstIdx;    // next burst slot
	// sample engine and storage
	isrp_word_t  outRegs [16];  // output registers, byte address / 2
	isrp_word_t  sampleCnt;     // running sample count
	logic [31:0] timer;         // sample period timer
	logic [3:0]  pulseCnt;      // strobe width counter

	// edges seen on the synchronised serial clock, only inside a frame
	wire         selActive  = ~selSync[1];
	wire         sclkRise   = selActive & sclkSync[1] & ~sclkSync[2];
	wire         sclkFall   = selActive & ~sclkSync[1] & sclkSync[2];
	wire         frameDone  = sclkRise & (bitCnt == 4'hf);
	wire isrp_word_t rxWord = {rxShift[14:0], mosiSync[1]};
	wire         isWrite    = rxWord[RW_BIT];
	wire [6:0]   reqAddr    = rxWord[ADDR_MSB:ADDR_LSB];
	wire [7:0]   wrByte     = rxWord[7:0];
	wire         burstStart = frameDone & ~isWrite & ~burstActive & (reqAddr == ADDR_GLOB);
	wire         loadBurst  = frameDone & (burstActive | burstStart);
	wire [3:0]   slotIdx    = burstStart ? 4'h0 : burstIdx;
	wire [6:0]   txAddr     = loadBurst ? isrp_burst_addr(slotIdx) : reqAddr;
	wire         isOutBlock = (txAddr[6:5] == 2'h0);
	wire isrp_word_t regData = isOutBlock ? outRegs[txAddr[4:1]] :
		((txAddr[6:1] == ADDR_MISC[6:1]) ? miscCtrl : '0);
	wire isrp_word_t checksum = isrp_bytes(outRegs[ADDR_DIAG[4:1]]) + isrp_bytes(outRegs[ADDR_RATE_X[4:1]]) +
		isrp_bytes(outRegs[ADDR_RATE_Y[4:1]]) + isrp_bytes(outRegs[ADDR_RATE_Z[4:1]]) +
		isrp_bytes(outRegs[ADDR_ACCL_X[4:1]]) + isrp_bytes(outRegs[ADDR_ACCL_Y[4:1]]) +
		isrp_bytes(outRegs[ADDR_ACCL_Z[4:1]]) + isrp_bytes(outRegs[ADDR_SMPL[4:1]]);
	wire isrp_word_t nextTx = (loadBurst && slotIdx == BURST_LAST) ? checksum :
		((frameDone & isWrite & ~burstActive) ? '0 : regData);
	// control decode
	wire [1:0]   syncMode   = miscCtrl[SYNC_MODE_LSB +: 2];
	// a burst ignores request words, so a restart byte inside one must not act either
	wire         restartCmd = frameDone & isWrite & ~burstActive & (reqAddr == ADDR_GLOB) &
		wrByte[GLOB_RESTART_BIT];
	wire         extSync    = (syncMode == SYNC_MODE_IN);
	wire         syncRise   = syncPinSync[1] & ~syncPinSync[2];
	wire         timerEnd   = (timer == SAMPLE_CYC - 1);
	wire         next_tick  = extSync ? syncRise : timerEnd;

	// two flip-flop synchronisers on every pin; the device never drives clock or select
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sclkSync    <= 3'h7;
			selSync     <= 2'h3;
			mosiSync    <= 2'h0;
			syncPinSync <= 3'h7;
		end else begin
			sclkSync    <= {sclkSync[1:0], link.sclk};
			selSync     <= {selSync[0], link.selN};
			mosiSync    <= {mosiSync[0], link.mosi};
			syncPinSync <= {syncPinSync[1:0], link.syncLevel};
		end
	end

	// receive side: count and shift on rising edges, restart when select rises
	always_ff @(posedge core_clk) begin
		if (rst || !selActive) begin
			bitCnt  <= 4'h0;
			rxShift <= '0;
		end else if (sclkRise) begin
			bitCnt  <= bitCnt + 4'h1; // wraps to zero at frame end for streamed frames
			rxShift <= rxWord;
		end
	end

	// transmit side: answer loaded at frame end, shifted out on falling edges
	always_ff @(posedge core_clk) begin
		if (rst) begin
			txShift <= '0;
			misoBit <= 1'b0;
		end else if (frameDone) begin
			txShift <= nextTx;
		end else if (sclkFall) begin
			misoBit <= txShift[15];
			txShift <= {txShift[14:0], 1'b0};
		end
	end

	// burst walk: ten words, then plain reads resume; select rising ends it early
	always_ff @(posedge core_clk) begin
		if (rst || !selActive) begin
			burstActive <= 1'b0;
			burstIdx    <= 4'h0;
		end else if (loadBurst) begin
			burstActive <= (slotIdx != BURST_LAST);
			burstIdx    <= slotIdx + 4'h1;
		end
	end

	// control register: byte writes to low and high halves
	always_ff @(posedge core_clk) begin
		if (rst) begin
			miscCtrl <= MISC_RESET;
		end else if (frameDone && isWrite && !burstActive && reqAddr[6:1] == ADDR_MISC[6:1]) begin
			if (reqAddr[0]) begin
				miscCtrl[15:8] <= wrByte;
			end else begin
				miscCtrl[7:0] <= wrByte;
			end
		end
	end

	// sample timer runs from reset release without any command
	always_ff @(posedge core_clk) begin
		if (rst || restartCmd || timerEnd) begin
			timer <= '0;
		end else begin
			timer <= timer + 32'h1;
		end
	end

	// refresh the output registers; held during a burst so the checksum stays consistent
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sampleCnt <= '0;
			for (int i = 0; i < 16; i++) begin
				outRegs[i] <= '0;
			end
		end else if (restartCmd) begin
			sampleCnt <= '0;
		end else if (next_tick) begin
			sampleCnt <= sampleCnt + 16'h1;
			if (!burstActive) begin
				for (int i = 0; i < 16; i++) begin
					outRegs[i] <= isrp_fresh(4'(i), rateX, rateY, rateZ, accelX, accelY, accelZ, tempIn,
						diagIn, sampleCnt + 16'h1);
				end
			end
		end
	end

	// strobe stretcher: high for a fixed count after every sample
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pulseCnt   <= 4'h0;
			sampleTick <= 1'b0;
		end else begin
			sampleTick <= next_tick;
			if (next_tick) begin
				pulseCnt <= 4'(DONE_PULSE_CYC);
			end else if (pulseCnt != 4'h0) begin
				pulseCnt <= pulseCnt - 4'h1;
			end
		end
	end

	// pin drive; sync drives the strobe out only in output mode
	assign link.miso       = misoBit;
	assign link.sampleDone = (pulseCnt != 4'h0);
	assign link.syncDevOut = (pulseCnt != 4'h0);
	assign link.syncDevOe  = (syncMode == SYNC_MODE_OUT);
endmodule : isrp_sensor_port
`default_nettype wire

// File: inc/isrp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface isrp_link_if;
	logic sclk;        // serial clock, made by the host, idles high
	logic selN;        // frame select, active low
	logic mosi;        // host to device data
	logic miso;        // device to host data
	logic sampleDone;  // sample-done strobe from the device
	logic syncDevOut;  // sync pin, device drive value
	logic syncDevOe;   // sync pin, device drives while high
	logic syncHostOut; // sync pin, host drive value
	logic syncHostOe;  // sync pin, host drives while high
	wire  syncLevel;   // resolved sync pin, pulled high when nobody drives
	assign syncLevel = syncDevOe ? syncDevOut : (syncHostOe ? syncHostOut : 1'b1);
	modport dev  (input sclk, selN, mosi, syncLevel, output miso, sampleDone, syncDevOut, syncDevOe);
	modport host (output sclk, selN, mosi, syncHostOut, syncHostOe, input miso, sampleDone, syncLevel);
endinterface : isrp_link_if
`default_nettype wire

// File: inc/isrp_pkg.sv
`default_nettype none
package isrp_pkg;
	// clocking of both ends
	localparam int unsigned CLK_HZ            = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS     = 40;
	// sample engine
	localparam int unsigned SAMPLE_RATE_SPS   = 2048;
	localparam int unsigned SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_SPS;
	localparam int unsigned DONE_PULSE_CYC    = 8;
	// frame shape
	localparam int unsigned FRAME_BITS        = 16;
	localparam int unsigned RW_BIT            = 15;
	localparam int unsigned ADDR_MSB          = 14;
	localparam int unsigned ADDR_LSB          = 8;
	// link timing, least times rounded up
	localparam int unsigned STALL_NS          = 16000;
	localparam int unsigned STALL_CYC         = (STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CS_SETUP_NS       = 200;
	localparam int unsigned CS_SETUP_CYC      = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SCLK_MAX_HZ       = 1_000_000;
	localparam int unsigned SCLK_HALF_CYC     = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
	// register byte addresses
	localparam logic [6:0] ADDR_DIAG   = 7'h02;
	localparam logic [6:0] ADDR_RATE_X = 7'h06;
	localparam logic [6:0] ADDR_RATE_Y = 7'h0a;
	localparam logic [6:0] ADDR_RATE_Z = 7'h0e;
	localparam logic [6:0] ADDR_ACCL_X = 7'h12;
	localparam logic [6:0] ADDR_ACCL_Y = 7'h16;
	localparam logic [6:0] ADDR_ACCL_Z = 7'h1a;
	localparam logic [6:0] ADDR_SMPL   = 7'h1c;
	localparam logic [6:0] ADDR_TEMP   = 7'h1e;
	localparam logic [6:0] ADDR_MISC   = 7'h32;
	localparam logic [6:0] ADDR_GLOB   = 7'h3e;
	// request words
	localparam logic [15:0] REQ_RATE_X = 16'h0600;
	localparam logic [15:0] REQ_RATE_Y = 16'h0a00;
	localparam logic [15:0] REQ_RATE_Z = 16'h0e00;
	localparam logic [15:0] REQ_BURST  = 16'h3e00;
	// control fields
	localparam logic [15:0] MISC_RESET       = 16'h00c1;
	localparam int unsigned SYNC_MODE_LSB    = 2;
	localparam logic [1:0]  SYNC_MODE_OUT    = 2'h0;
	localparam logic [1:0]  SYNC_MODE_IN     = 2'h1;
	localparam int unsigned GLOB_RESTART_BIT = 7;
	localparam logic [3:0]  BURST_LAST       = 4'h9;
	localparam int unsigned FIFO_DEPTH       = 16;
	typedef logic [15:0] isrp_word_t;
endpackage : isrp_pkg
`default_nettype wire

// File: sim/isrp_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the link between the two ends
module isrp_link_chk
	import isrp_pkg::*;
#(
	parameter int unsigned SAMPLE_CYC = SAMPLE_PERIOD_CYC // cycles per sample
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic selN,
	input wire logic miso,
	input wire logic sampleDone,
	input wire logic syncDevOe
);
	logic        prevSclk; // sclk one cycle back
	logic        prevDone; // strobe one cycle back
	logic [7:0]  lowCnt;   // length of the running sclk low phase
	logic [15:0] highCnt;  // select high time, saturates
	logic [8:0]  riseCnt;  // sclk rises since select fell
	int unsigned gapCnt;   // cycles since the last strobe rise
	logic        seen;     // timer strobe seen, cleared while sync is an input
	wire         sclkRise = sclk & ~prevSclk;
	wire         doneRise = sampleDone & ~prevDone;
	// counters stay short; the saturation keeps the first frame after reset legal
	always_ff @(posedge core_clk) begin
		prevSclk <= rst | sclk;
		prevDone <= ~rst & sampleDone;
		lowCnt   <= (rst | sclk) ? 8'h00 : lowCnt + 8'h01;
		highCnt  <= rst ? 16'hffff : (!selN ? 16'h0000 : highCnt + {15'h0, highCnt != 16'hffff});
		riseCnt  <= (rst | selN) ? 9'h000 : riseCnt + {8'h00, sclkRise};
		gapCnt   <= rst ? 0 : (doneRise ? 1 : gapCnt + 1);
		seen     <= (rst | ~syncDevOe) ? 1'b0 : (seen | doneRise);
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_sclk_idle_high: assert property (selN |-> sclk)
		else $error("serial clock low while deselected");
	a_sel_setup: assert property ($fell(selN) |-> sclk [*5])
		else $error("serial clock moved too soon after select");
	a_frame_bits: assert property ($rose(selN) |-> riseCnt[3:0] == 4'h0 && riseCnt != 9'h000)
		else $error("frame not a whole number of sixteen bits");
	a_low_phase: assert property (sclkRise && !selN |-> lowCnt >= 8'h0d)
		else $error("serial clock low phase too short");
	a_miso_hold: assert property (sclkRise && !selN |-> $stable(miso))
		else $error("device data moved at a rising edge");
	a_done_width: assert property ($rose(sampleDone) |-> sampleDone [*8] ##1 !sampleDone)
		else $error("strobe width wrong");
	a_done_period: assert property (doneRise && seen |-> gapCnt == SAMPLE_CYC)
		else $error("sample period wrong");
	a_stall_gap: assert property ($fell(selN) |-> highCnt >= STALL_CYC)
		else $error("stall between frames too short");
endmodule : isrp_link_chk
`default_nettype wire

// File: sim/test_inertial_sensor_spi_read_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_inertial_sensor_spi_read_port
	import isrp_pkg::*;
;
	localparam int unsigned SIM_SAMPLE = 200; // short sample period
	logic       core_clk    = 1'b0;
	logic       rst         = 1'b1;
	logic       reqValid    = 1'b0;
	logic       reqKeepSel  = 1'b0;
	logic       rdReady     = 1'b0;
	logic       syncDrive   = 1'b0;
	logic       syncDriveOe = 1'b0;
	isrp_word_t reqWord     = 16'h0000;
	isrp_word_t sens [8]    = '{default: 16'h0000}; // rates, accels, temp, diag
	logic       reqReady, rdValid, sampleSeen, sampleTick;
	isrp_word_t rdWord, miscCtrl;
	int         numErrors   = 0;
	int         checksDone  = 0;
	isrp_link_if link ();
	isrp_sensor_port #(.SAMPLE_CYC(SIM_SAMPLE)) u_isrp_sensor_port (.core_clk(core_clk), .rst(rst),
		.link(link), .rateX(sens[0]), .rateY(sens[1]), .rateZ(sens[2]), .accelX(sens[3]),
		.accelY(sens[4]), .accelZ(sens[5]), .tempIn(sens[6]), .diagIn(sens[7]), .sampleTick(sampleTick),
		.miscCtrl(miscCtrl));
	isrp_host_port u_isrp_host_port (.core_clk(core_clk), .rst(rst), .link(link), .reqValid(reqValid),
		.reqReady(reqReady), .reqWord(reqWord), .reqKeepSel(reqKeepSel), .rdValid(rdValid),
		.rdReady(rdReady), .rdWord(rdWord), .sampleSeen(sampleSeen), .syncDrive(syncDrive),
		.syncDriveOe(syncDriveOe));
	isrp_link_chk #(.SAMPLE_CYC(SIM_SAMPLE)) u_isrp_link_chk (.core_clk(core_clk), .rst(rst),
		.sclk(link.sclk), .selN(link.selN), .miso(link.miso), .sampleDone(link.sampleDone),
		.syncDevOe(link.syncDevOe));
	// 25 MHz core clock
	always #20 core_clk = ~core_clk;
	// verdict and end of run
	task automatic stopTest();
		if (numErrors == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stopTest
	task automatic checkWord(input isrp_word_t got, input isrp_word_t exp);
		checksDone++;
		if (got !== exp) begin
			numErrors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : checkWord
	task automatic checkBit(input logic got, input logic exp);
		checkWord({15'h0, got}, {15'h0, exp});
	endtask : checkBit
	// offer one request, held until taken; a hang counts as a mismatch
	task automatic sendReq(input isrp_word_t w, input logic keep);
		logic ok;
		ok = 1'b0;
		@(posedge core_clk);
		reqValid   <= 1'b1;
		reqWord    <= w;
		reqKeepSel <= keep;
		for (int n = 0; n < 5000 && !ok; n++) begin
			@(negedge core_clk);
			ok = (reqReady === 1'b1);
			@(posedge core_clk);
		end
		reqValid <= 1'b0;
		if (!ok) begin
			numErrors++;
			stopTest();
		end
	endtask : sendReq
	// pop one received word
	task automatic getWord(output isrp_word_t w);
		logic ok;
		ok = 1'b0;
		@(posedge core_clk);
		rdReady <= 1'b1;
		for (int n = 0; n < 20000 && !ok; n++) begin
			@(negedge core_clk);
			ok = (rdValid === 1'b1);
			w  = rdWord;
			@(posedge core_clk);
		end
		rdReady <= 1'b0;
		if (!ok) begin
			numErrors++;
			stopTest();
		end
	endtask : getWord
	task automatic xfer(input isrp_word_t req, output isrp_word_t w);
		sendReq(req, 1'b0);
		getWord(w);
	endtask : xfer
	// new sensor words, then two sample periods so they reach the outputs
	task automatic setSens(input isrp_word_t b);
		@(posedge core_clk);
		for (int i = 0; i < 8; i++) sens[i] <= b + 16'(i);
		repeat (2 * SIM_SAMPLE + 20) @(posedge core_clk);
	endtask : setSens
	// idle levels, reset values, sampling starts unasked
	task automatic testReset();
		logic hit;
		int   ticks;
		hit   = 1'b0;
		ticks = 0;
		@(negedge core_clk);
		checkWord(miscCtrl, MISC_RESET);
		checkBit(link.syncDevOe, 1'b1);
		checkBit(link.selN, 1'b1);
		checkBit(link.sclk, 1'b1);
		repeat (SIM_SAMPLE + 50) begin
			@(negedge core_clk);
			hit |= (sampleSeen === 1'b1);
			ticks += (sampleTick === 1'b1) ? 1 : 0;
		end
		checkBit(hit, 1'b1);
		checkWord(16'(ticks), 16'h0001);
	endtask : testReset
	// control write, sync as input, then pipelined reads with junk low bytes
	task automatic testMisc();
		isrp_word_t w;
		logic       hit;
		setSens(16'h1200);
		xfer(16'hb2c5, w);
		@(negedge core_clk);
		checkWord(miscCtrl, 16'h00c5);
		checkBit(link.syncDevOe, 1'b0);
		repeat (20) @(posedge core_clk);
		hit = 1'b0;
		repeat (300) begin
			@(negedge core_clk);
			hit |= (link.sampleDone !== 1'b0);
		end
		checkBit(hit, 1'b0);
		// restart while sync is an input, so exactly one pin sample follows it
		xfer(16'hbe80, w);
		checkWord(w, 16'h0000);
		@(posedge core_clk);
		syncDriveOe <= 1'b1;
		repeat (10) @(posedge core_clk);
		syncDrive <= 1'b1;
		hit = 1'b0;
		repeat (100) begin
			@(negedge core_clk);
			hit |= (link.sampleDone === 1'b1);
		end
		@(posedge core_clk);
		syncDriveOe <= 1'b0;
		checkBit(hit, 1'b1);
		xfer(16'h1c00, w);
		checkWord(w, 16'h0000);
		xfer(16'hb2c1, w);
		checkWord(w, 16'h0001);
		checkBit(link.syncDevOe, 1'b1);
		xfer(16'h32ff, w);
		xfer(16'h06a5, w);
		checkWord(w, 16'h00c1);
		xfer(REQ_RATE_Y | 16'h005a, w);
		checkWord(w, sens[0]);
		xfer(16'h0eff, w);
		checkWord(w, sens[1]);
		xfer(16'h0000, w);
		checkWord(w, sens[2]);
	endtask : testMisc
	// streamed burst under one select, checksum over the byte pairs
	task automatic testBurst();
		isrp_word_t w [11];
		isrp_word_t e [8];
		isrp_word_t cs;
		setSens(16'h2300);
		e = '{sens[7], sens[0], sens[1], sens[2], sens[3], sens[4], sens[5], sens[6]};
		for (int i = 0; i < 11; i++) sendReq(i == 0 ? REQ_BURST : 16'h0000, i < 10);
		for (int i = 0; i < 11; i++) getWord(w[i]);
		cs = w[9][15:8] + w[9][7:0];
		for (int k = 0; k < 8; k++) begin
			checkWord(w[k + 1], e[k]);
			if (k < 7) cs = cs + e[k][15:8] + e[k][7:0];
		end
		checkWord(w[10], cs);
	endtask : testBurst
	// fill the answer buffer until it refuses, then drain it with stalls
	task automatic testFifo();
		isrp_word_t w;
		logic       hit;
		setSens(16'h3400);
		for (int i = 0; i < 16; i++) sendReq(REQ_RATE_Y, 1'b0);
		@(posedge core_clk);
		reqValid <= 1'b1;
		hit = 1'b0;
		repeat (1200) begin
			@(negedge core_clk);
			hit |= (reqReady !== 1'b0);
		end
		@(posedge core_clk);
		reqValid <= 1'b0;
		checkBit(hit, 1'b0);
		for (int i = 0; i < 16; i++) begin
			repeat (i) @(posedge core_clk);
			getWord(w);
			if (i > 0) checkWord(w, sens[1]);
		end
		@(negedge core_clk);
		checkBit(rdValid, 1'b0);
	endtask : testFifo
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		testReset();
		testMisc();
		testBurst();
		testFifo();
		stopTest();
	end
endmodule : test_inertial_sensor_spi_read_port
`default_nettype wire
